// ==== hdl/cfg_regs_consts.svh ====
// offsets, field positions, reset values and timing counts of the config block
// assumes a 20 MHz core clock and a 16-bit lsb-first serial frame
`ifndef CFG_REGS_CONSTS_SVH
`define CFG_REGS_CONSTS_SVH

`define ADDR_LOCK0_REG 7'h0e
`define ADDR_PUMP_CTRL 7'h0f
`define ADDR_PUMP_EN 7'h15
`define ADDR_PIN_MODE 7'h17
`define ADDR_DUTY 7'h18
`define ADDR_PERIOD_FREQ_SETTING 7'h1c

`define LOCK0_BIT 3
`define PUMP_EN_BIT 0
`define LOCK1_BIT 0

`define PUMP_CTRL_POR 8'h40
`define PIN_MODE_POR 3'h0
`define DUTY_POR 8'h00
`define PERIOD_FREQ_SETTING_POR 2'h0

`define PIN_CYCLIC 3'h3
`define PIN_OFF 3'h4
`define PIN_WAKE 3'h5
`define PIN_PWM_LS 3'h6
`define PIN_PWM_HS 3'h7

`define FRAME_BITS 5'h10
`define FRAME_HALF 5'h07

`define CLK_HZ 20000000
`define CLK_PERIOD_NS 50
`define WAKE_FILTER_NS 16000
`define WAKE_FILTER_CYC ((`WAKE_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define PWM_STEPS 255
`define PWM_F0_HZ 100
`define PWM_F1_HZ 200
`define PWM_F2_HZ 325
`define PWM_F3_HZ 400
`define PWM_STEP_CYC(f) (`CLK_HZ / ((f) * `PWM_STEPS))

`endif

// ==== hdl/cfg_regs_pkg.sv ====
// types shared by the config register block and its helpers
// no dependencies
package cfg_regs_pkg;

  typedef struct packed {
    logic [2:0] switch_freq;
    logic peak_sel;
    logic [1:0] spread_rate;
  } pump_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic wr;
    logic [6:0] addr;
  } frame_t;

  typedef struct packed {
    logic fail_output;
    logic cyclic_sense;
    logic pin_off;
    logic wake_input;
    logic pwm_ls;
    logic pwm_hs;
  } pin_use_t;

  typedef enum logic {SER_IDLE, SER_FRAME} ser_state_t;

endpackage

// ==== hdl/config_lock_gpio_pwm_regs.sv ====
// config registers: two-level lock, pump oscillator settings, pin mode and pwm duty
// assumes serial port pins synchronous to clk; rst_n is the power-on reset
`timescale 1ns/10ps
`include "cfg_regs_consts.svh"

// Function
// - level-0 lock blocks pump enable, pin mode
// - locked bits survive soft reset
// - level-1 lock freezes other lockable bits
// - level-1 lock active after frame end, self-locking
// - level-1 lock bit kept through soft reset
// - bits 7:5 select pump oscillator frequency
// - bit 4 selects regulator peak threshold
// - bits 3:2 select spread-spectrum rate
// - reserved bits always read zero
// - pump register 0x40 at power-on, kept otherwise
// - pin mode field decodes pin function
// - wake input uses 16 us static filter
// - pin mode zero at power-on, mode-dependent otherwise
// - wake input enabled by default in fail-safe
// - duty 0 off, 255 on, else fraction
// - duty cleared by power-on, soft reset only
// - apply pump settings once long reset delay expires
// - new duty waits for period end
// - four pwm rates, change waits period end
module config_lock_gpio_pwm_regs
  import cfg_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // chip mode events
  input wire logic soft_reset,
  input wire logic restart_pulse,
  input wire logic reset_delay_done,
  input wire logic fail_safe_mode,
  input wire logic wake_src_enable,
  // serial register port
  input wire logic select_line_n,
  input wire logic spi_clk,
  input wire logic spi_di,
  output logic spi_do,
  // multi-purpose pin
  input wire logic pin_in,
  // settings to the analog side
  output logic pump_output_enable,
  output pump_cfg_t pump_cfg,
  output pin_use_t pin_use,
  output logic pwm_ls_drive,
  output logic pwm_hs_drive,
  output logic wake_hit
);

  // ---------------- serial port ----------------
  ser_state_t state_r, state_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [7:0] rd_buf_r, rd_buf_nxt;
  logic [7:0] rd_mux;
  logic sclk_q_r, sdo_r, sdo_nxt;
  logic sclk_rise, sclk_fall, commit;
  frame_t frame_v, frame_nxt_v;

  // register state
  logic lock0_r, lock0_nxt;
  logic lock1_r, lock1_nxt;
  pump_cfg_t pump_cfg_r, pump_cfg_nxt;
  logic pump_en_r, pump_en_nxt;
  logic [2:0] pin_mode_r, pin_mode_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic [1:0] period_freq_setting_r, period_freq_setting_nxt;

  // applied outputs
  pump_cfg_t pump_out_r, pump_out_nxt;
  pin_use_t pin_use_r, pin_use_nxt;
  logic pump_en_out_r, ls_r, hs_r, wake_hit_r;
  logic ls_nxt, hs_nxt, wake_hit_nxt;
  logic pwm_raw, wake_pulse;

  assign frame_v = frame_t'(shift_r);
  assign frame_nxt_v = frame_t'(shift_nxt);
  assign sclk_rise = spi_clk && !sclk_q_r;
  assign sclk_fall = !spi_clk && sclk_q_r;
  // only a frame of at least 16 bits is acted on; short frames are dropped, bits past 16 are ignored
  assign commit = state_r == SER_FRAME && select_line_n && bit_cnt_r == `FRAME_BITS;

  // switch modes fall back to off; fail output, off and wake survive
  function automatic logic [2:0] pin_mode_kept(input logic [2:0] m);
    if (m == `PIN_CYCLIC || m == `PIN_PWM_LS || m == `PIN_PWM_HS) begin
      pin_mode_kept = `PIN_OFF;
    end else begin
      pin_mode_kept = m;
    end
  endfunction

  function automatic pin_use_t pin_decode(input logic [2:0] m);
    pin_decode = '0;
    case (m)
      `PIN_CYCLIC: pin_decode.cyclic_sense = 1'b1;
      `PIN_OFF: pin_decode.pin_off = 1'b1;
      `PIN_WAKE: pin_decode.wake_input = 1'b1;
      `PIN_PWM_LS: pin_decode.pwm_ls = 1'b1;
      `PIN_PWM_HS: pin_decode.pwm_hs = 1'b1;
      default: pin_decode.fail_output = 1'b1;
    endcase
  endfunction

  // read view; reserved positions stay zero
  always_comb begin
    case (frame_nxt_v.data[6:0])
      `ADDR_LOCK0_REG: rd_mux = 8'(lock0_r) << `LOCK0_BIT;
      `ADDR_PUMP_CTRL: rd_mux = {pump_cfg_r, 1'b0, lock1_r};
      `ADDR_PUMP_EN: rd_mux = 8'(pump_en_r) << `PUMP_EN_BIT;
      `ADDR_PIN_MODE: rd_mux = {5'h00, pin_mode_r};
      `ADDR_DUTY: rd_mux = duty_r;
      `ADDR_PERIOD_FREQ_SETTING: rd_mux = {6'h00, period_freq_setting_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    rd_buf_nxt = rd_buf_r;
    sdo_nxt = sdo_r;
    case (state_r)
      SER_IDLE: begin
        if (!select_line_n) begin
          state_nxt = SER_FRAME;
          bit_cnt_nxt = 5'h00;
          sdo_nxt = 1'b0;
        end
      end
      SER_FRAME: begin
        if (select_line_n) begin
          state_nxt = SER_IDLE;
          sdo_nxt = 1'b0;
        end else if (sclk_rise && bit_cnt_r != `FRAME_BITS) begin
          // lsb first: after eight bits address and direction sit in the top byte
          shift_nxt = {spi_di, shift_r[15:1]};
          bit_cnt_nxt = bit_cnt_r + 5'h01;
          if (bit_cnt_r == `FRAME_HALF) begin
            rd_buf_nxt = rd_mux;
          end
        end else if (sclk_fall && bit_cnt_r > `FRAME_HALF && bit_cnt_r != `FRAME_BITS) begin
          sdo_nxt = rd_buf_r[0];
          rd_buf_nxt = {1'b0, rd_buf_r[7:1]};
        end
      end
      default: state_nxt = SER_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= SER_IDLE;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      rd_buf_r <= 8'h00;
      sdo_r <= 1'b0;
      sclk_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      rd_buf_r <= rd_buf_nxt;
      sdo_r <= sdo_nxt;
      sclk_q_r <= spi_clk;
    end
  end

  // ---------------- register file ----------------
  always_comb begin
    lock0_nxt = lock0_r;
    lock1_nxt = lock1_r;
    pump_cfg_nxt = pump_cfg_r;
    pump_en_nxt = pump_en_r;
    pin_mode_nxt = pin_mode_r;
    duty_nxt = duty_r;
    period_freq_setting_nxt = period_freq_setting_r;
    if (soft_reset) begin
      // pump settings and level-1 lock hold: their soft reset value is the kept one
      if (!lock0_r) begin
        pin_mode_nxt = pin_mode_kept(pin_mode_r);
        pump_en_nxt = 1'b0;
      end
      duty_nxt = `DUTY_POR;
      period_freq_setting_nxt = `PERIOD_FREQ_SETTING_POR;
    end else if (restart_pulse) begin
      // duty and rate retained across restart
      pin_mode_nxt = pin_mode_kept(pin_mode_r);
    end else if (commit && frame_v.wr) begin
      case (frame_v.addr)
        `ADDR_LOCK0_REG: lock0_nxt = frame_v.data[`LOCK0_BIT];
        `ADDR_PUMP_CTRL: begin
          // once set, the lock covers itself until power-on
          if (!lock1_r) begin
            pump_cfg_nxt = pump_cfg_t'(frame_v.data[7:2]);
            lock1_nxt = frame_v.data[`LOCK1_BIT];
          end
        end
        `ADDR_PUMP_EN: begin
          if (!lock0_r) begin
            pump_en_nxt = frame_v.data[`PUMP_EN_BIT];
          end
        end
        `ADDR_PIN_MODE: begin
          if (!lock0_r) begin
            pin_mode_nxt = frame_v.data[2:0];
          end
        end
        `ADDR_DUTY: duty_nxt = frame_v.data;
        `ADDR_PERIOD_FREQ_SETTING: period_freq_setting_nxt = frame_v.data[1:0];
        default: duty_nxt = duty_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock0_r <= 1'b0;
      lock1_r <= 1'(`PUMP_CTRL_POR & 8'h01);
      pump_cfg_r <= pump_cfg_t'(6'(`PUMP_CTRL_POR >> 2));
      pump_en_r <= 1'b0;
      pin_mode_r <= `PIN_MODE_POR;
      duty_r <= `DUTY_POR;
      period_freq_setting_r <= `PERIOD_FREQ_SETTING_POR;
    end else begin
      lock0_r <= lock0_nxt;
      lock1_r <= lock1_nxt;
      pump_cfg_r <= pump_cfg_nxt;
      pump_en_r <= pump_en_nxt;
      pin_mode_r <= pin_mode_nxt;
      duty_r <= duty_nxt;
      period_freq_setting_r <= period_freq_setting_nxt;
    end
  end

  // ---------------- pin function ----------------
  pwm_engine #(
    .STEP_CYC_0(`PWM_STEP_CYC(`PWM_F0_HZ)),
    .STEP_CYC_1(`PWM_STEP_CYC(`PWM_F1_HZ)),
    .STEP_CYC_2(`PWM_STEP_CYC(`PWM_F2_HZ)),
    .STEP_CYC_3(`PWM_STEP_CYC(`PWM_F3_HZ))
  ) u_pwm (
    .clk(clk),
    .rst_n(rst_n),
    .enable(pin_use_r.pwm_ls || pin_use_r.pwm_hs),
    .duty(duty_r),
    .freq_sel(period_freq_setting_r),
    .pwm_out_r(pwm_raw)
  );

  wake_filter #(
    .FILTER_CYC(`WAKE_FILTER_CYC)
  ) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .enable(pin_use_r.wake_input),
    .pin_in(pin_in),
    .level_r(),
    .wake_pulse_r(wake_pulse)
  );

  always_comb begin
    // pump settings follow the register only once the reset delay is over
    pump_out_nxt = reset_delay_done ? pump_cfg_r : pump_out_r;
    pin_use_nxt = pin_decode(pin_mode_r);
    ls_nxt = pin_use_r.pwm_ls && pwm_raw;
    hs_nxt = pin_use_r.pwm_hs && pwm_raw;
    // fail-safe opens the wake path regardless of the outside enable
    wake_hit_nxt = wake_pulse && pin_use_r.wake_input && (wake_src_enable || fail_safe_mode);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pump_out_r <= pump_cfg_t'(6'(`PUMP_CTRL_POR >> 2));
      pin_use_r <= pin_decode(`PIN_MODE_POR);
      pump_en_out_r <= 1'b0;
      ls_r <= 1'b0;
      hs_r <= 1'b0;
      wake_hit_r <= 1'b0;
    end else begin
      pump_out_r <= pump_out_nxt;
      pin_use_r <= pin_use_nxt;
      pump_en_out_r <= pump_en_r;
      ls_r <= ls_nxt;
      hs_r <= hs_nxt;
      wake_hit_r <= wake_hit_nxt;
    end
  end

  assign spi_do = sdo_r;
  assign pump_output_enable = pump_en_out_r;
  assign pump_cfg = pump_out_r;
  assign pin_use = pin_use_r;
  assign pwm_ls_drive = ls_r;
  assign pwm_hs_drive = hs_r;
  assign wake_hit = wake_hit_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_to(logic [6:0] a);
    commit && frame_v.wr && frame_v.addr == a && !soft_reset && !restart_pulse;
  endsequence

  a_lock0_pin_hold: assert property (s_write_to(`ADDR_PIN_MODE) ##0 lock0_r |=> $stable(pin_mode_r))
    else $error("pin mode written under lock");
  a_lock0_pump_hold: assert property (s_write_to(`ADDR_PUMP_EN) ##0 lock0_r |=> $stable(pump_en_r))
    else $error("pump enable written under lock");
  a_lock1_cfg_hold: assert property (s_write_to(`ADDR_PUMP_CTRL) ##0 lock1_r |=> $stable(pump_cfg_r) && lock1_r)
    else $error("pump setting written under lock");
  a_lock1_frame_end: assert property ($rose(lock1_r) |-> $past(commit))
    else $error("lock set outside frame end");
  a_lock1_soft_keep: assert property (soft_reset && lock1_r |=> lock1_r ##1 lock1_r)
    else $error("lock lost on soft reset");
  a_soft_locked_pin: assert property (soft_reset && lock0_r |=> $stable(pin_mode_r) && $stable(pump_en_r))
    else $error("locked pin changed by soft reset");
  a_duty_soft_clear: assert property (soft_reset |=> duty_r == 8'h00 && period_freq_setting_r == 2'h0)
    else $error("duty not cleared");
  a_duty_restart_keep: assert property (restart_pulse && !soft_reset |=> $stable(duty_r))
    else $error("duty lost on restart");
  a_delay_hold: assert property (!reset_delay_done |=> $stable(pump_out_r))
    else $error("settings applied before delay");
  a_commit_only: assert property ($changed(duty_r) |-> $past(commit) || $past(soft_reset))
    else $error("duty changed outside frame end");

endmodule

// ==== hdl/pwm_engine.sv ====
// 255-step pwm generator with period-aligned reload of duty and rate
// assumes duty and rate inputs are stable register outputs
`timescale 1ns/10ps
module pwm_engine #(
  parameter int STEP_CYC_0 = 784,
  parameter int STEP_CYC_1 = 392,
  parameter int STEP_CYC_2 = 241,
  parameter int STEP_CYC_3 = 196
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // settings
  input wire logic enable,
  input wire logic [7:0] duty,
  input wire logic [1:0] freq_sel,
  // output
  output logic pwm_out_r
);

  logic [7:0] duty_act_r, duty_act_nxt;
  logic [1:0] freq_act_r, freq_act_nxt;
  logic [15:0] pre_r, pre_nxt;
  logic [7:0] step_r, step_nxt;
  logic out_nxt, step_end, period_end;

  function automatic logic [15:0] step_last(input logic [1:0] sel);
    case (sel)
      2'h0: step_last = 16'(STEP_CYC_0 - 1);
      2'h1: step_last = 16'(STEP_CYC_1 - 1);
      2'h2: step_last = 16'(STEP_CYC_2 - 1);
      default: step_last = 16'(STEP_CYC_3 - 1);
    endcase
  endfunction

  assign step_end = pre_r == step_last(freq_act_r);
  assign period_end = step_end && step_r == 8'hfe;

  always_comb begin
    pre_nxt = pre_r;
    step_nxt = step_r;
    duty_act_nxt = duty_act_r;
    freq_act_nxt = freq_act_r;
    if (!enable) begin
      // idle: restart cleanly so the first period uses fresh settings
      pre_nxt = 16'h0000;
      step_nxt = 8'h00;
      duty_act_nxt = duty;
      freq_act_nxt = freq_sel;
    end else if (period_end) begin
      pre_nxt = 16'h0000;
      step_nxt = 8'h00;
      duty_act_nxt = duty;
      freq_act_nxt = freq_sel;
    end else if (step_end) begin
      pre_nxt = 16'h0000;
      step_nxt = step_r + 8'h01;
    end else begin
      pre_nxt = pre_r + 16'h0001;
    end
    // 0 never on, 255 beats every step index 0..254
    out_nxt = enable && (step_r < duty_act_r);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_r <= 16'h0000;
      step_r <= 8'h00;
      duty_act_r <= 8'h00;
      freq_act_r <= 2'h0;
      pwm_out_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      step_r <= step_nxt;
      duty_act_r <= duty_act_nxt;
      freq_act_r <= freq_act_nxt;
      pwm_out_r <= out_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pwm_full_on: assert property (enable && duty_act_r == 8'hff |=> pwm_out_r)
    else $error("full duty not on");
  a_pwm_zero_off: assert property (duty_act_r == 8'h00 |=> !pwm_out_r)
    else $error("zero duty not off");
  a_duty_period_load: assert property ($changed(duty_act_r) |-> $past(period_end) || !$past(enable))
    else $error("duty reloaded mid period");
  a_freq_period_load: assert property ($changed(freq_act_r) |-> $past(period_end) || !$past(enable))
    else $error("rate reloaded mid period");

endmodule

// ==== hdl/wake_filter.sv ====
// static glitch filter for the multi-purpose pin used as wake input
// assumes pin_in is already synchronous to clk
`timescale 1ns/10ps
module wake_filter #(
  parameter int FILTER_CYC = 320
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin
  input wire logic enable,
  input wire logic pin_in,
  // result
  output logic level_r,
  output logic wake_pulse_r
);

  logic [15:0] cnt_r, cnt_nxt;
  logic level_nxt, pulse_nxt;

  // level only moves after the input has held its new value the whole window
  always_comb begin
    cnt_nxt = 16'h0000;
    level_nxt = level_r;
    pulse_nxt = 1'b0;
    if (enable && pin_in != level_r) begin
      if (cnt_r == 16'(FILTER_CYC - 1)) begin
        level_nxt = pin_in;
        pulse_nxt = pin_in;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
      level_r <= 1'b0;
      wake_pulse_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
      wake_pulse_r <= pulse_nxt;
    end
  end

  a_wake_static_len: assert property (@(posedge clk) disable iff (!rst_n)
    wake_pulse_r |-> $past(cnt_r) == 16'(FILTER_CYC - 1)) else $error("wake accepted early");

endmodule

// ==== tb/config_lock_gpio_pwm_regs_test.sv ====
// self-checking bench for the config register block
// assumes host_model as serial master; wake filter left at its default length
`timescale 1ns/10ps
`include "cfg_regs_consts.svh"
module config_lock_gpio_pwm_regs_test;
  import cfg_regs_pkg::*;
  logic clk, rst_n, soft_reset, restart_pulse, reset_delay_done, fail_safe_mode, wake_src_enable, pin_in;
  logic select_line_n, spi_clk, spi_di, spi_do;
  logic pump_output_enable, pwm_ls_drive, pwm_hs_drive, wake_hit;
  pump_cfg_t pump_cfg;
  pin_use_t pin_use;
  int num_errors, num_checks, cyc, hits, on_cyc;
  logic [7:0] rd, v;

  config_lock_gpio_pwm_regs DUT (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .restart_pulse(restart_pulse), .reset_delay_done(reset_delay_done), .fail_safe_mode(fail_safe_mode),
    .wake_src_enable(wake_src_enable), .select_line_n(select_line_n), .spi_clk(spi_clk), .spi_di(spi_di),
    .spi_do(spi_do), .pin_in(pin_in), .pump_output_enable(pump_output_enable), .pump_cfg(pump_cfg),
    .pin_use(pin_use), .pwm_ls_drive(pwm_ls_drive), .pwm_hs_drive(pwm_hs_drive), .wake_hit(wake_hit));

  host_model host (.clk(clk), .select_line_n(select_line_n), .spi_clk(spi_clk), .spi_di(spi_di),
    .spi_do(spi_do));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // expected run is about 10200 cycles
  always @(posedge clk) begin
    cyc++;
    if (wake_hit === 1'b1) begin
      hits++;
    end
    if (pwm_ls_drive === 1'b1) begin
      on_cyc++;
    end
    if (cyc == 30000) begin
      num_errors++;
      print_verdict();
    end
  end

  task check(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [6:0] addr, input logic [7:0] data);
    host.frame(addr, 1'b1, data, 16, rd);
  endtask

  task rdchk(input logic [6:0] addr, input logic [7:0] exp, input string what);
    host.frame(addr, 1'b0, 8'h00, 16, rd);
    check(what, rd, exp);
  endtask

  task do_soft();
    soft_reset = 1'b1;
    host.wait_cyc(1);
    soft_reset = 1'b0;
    host.wait_cyc(2);
  endtask

  task do_restart();
    restart_pulse = 1'b1;
    host.wait_cyc(1);
    restart_pulse = 1'b0;
    host.wait_cyc(2);
  endtask

  // pin high for n cycles, then low long enough for the filter to settle
  task wake_pulse(input int n, input logic [7:0] exp);
    hits = 0;
    pin_in = 1'b1;
    host.wait_cyc(n);
    pin_in = 1'b0;
    host.wait_cyc(400);
    check("wake_hit", hits[7:0], exp);
  endtask

  initial begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    restart_pulse = 1'b0;
    fail_safe_mode = 1'b0;
    wake_src_enable = 1'b0;
    pin_in = 1'b0;
    reset_delay_done = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    host.wait_cyc(2);
    check("pump_cfg", {2'b00, pump_cfg}, 8'h10);
    check("pin_use", {2'b00, pin_use}, 8'h20);
    rdchk(`ADDR_PUMP_CTRL, `PUMP_CTRL_POR, "pump_ctrl");
    rdchk(`ADDR_PIN_MODE, 8'h00, "pin_mode");
    rdchk(`ADDR_DUTY, `DUTY_POR, "duty");
    rdchk(`ADDR_LOCK0_REG, 8'h00, "lock0");
    rdchk(7'h30, 8'h00, "unmapped");
    // settings held until the long reset delay is over
    reset_delay_done = 1'b0;
    wr(`ADDR_PUMP_CTRL, 8'h00);
    check("pump_cfg held", {2'b00, pump_cfg}, 8'h10);
    reset_delay_done = 1'b1;
    host.wait_cyc(2);
    check("pump_cfg applied", {2'b00, pump_cfg}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = {3'(i), 1'(i), 2'(i), 2'b10};
      wr(`ADDR_PUMP_CTRL, v);
      rdchk(`ADDR_PUMP_CTRL, v & 8'hfc, "pump_ctrl");
      check("pump_cfg", {2'b00, pump_cfg}, {2'b00, v[7:2]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(`ADDR_PIN_MODE, 8'hf8 | 8'(i));
      rdchk(`ADDR_PIN_MODE, 8'(i), "pin_mode");
      check("pin_use", {2'b00, pin_use}, (i < 3) ? 8'h20 : 8'h20 >> (i - 2));
    end
    wr(`ADDR_PIN_MODE, `PIN_OFF);
    wr(`ADDR_DUTY, 8'hff);
    wr(`ADDR_PIN_MODE, `PIN_PWM_LS);
    host.wait_cyc(4);
    check("ls full on", {7'h00, pwm_ls_drive}, 8'h01);
    check("hs idle", {7'h00, pwm_hs_drive}, 8'h00);
    wr(`ADDR_DUTY, 8'h00);
    check("duty waits period", {7'h00, pwm_ls_drive}, 8'h01);
    wr(`ADDR_PIN_MODE, `PIN_OFF);
    wr(`ADDR_PIN_MODE, `PIN_PWM_HS);
    host.wait_cyc(4);
    check("hs full off", {7'h00, pwm_hs_drive}, 8'h00);
    wr(`ADDR_DUTY, 8'h80);
    do_restart();
    rdchk(`ADDR_DUTY, 8'h80, "duty restart");
    rdchk(`ADDR_PIN_MODE, `PIN_OFF, "pin restart");
    do_soft();
    rdchk(`ADDR_DUTY, 8'h00, "duty soft");
    wr(`ADDR_PUMP_EN, 8'h01);
    check("pump_en", {7'h00, pump_output_enable}, 8'h01);
    wr(`ADDR_PIN_MODE, `PIN_CYCLIC);
    wr(`ADDR_LOCK0_REG, 8'h08);
    rdchk(`ADDR_LOCK0_REG, 8'h08, "lock0");
    wr(`ADDR_PIN_MODE, `PIN_WAKE);
    wr(`ADDR_PUMP_EN, 8'h00);
    rdchk(`ADDR_PIN_MODE, `PIN_CYCLIC, "pin locked");
    check("pump_en locked", {7'h00, pump_output_enable}, 8'h01);
    rdchk(`ADDR_PUMP_EN, 8'h01, "pump_en reg");
    do_soft();
    rdchk(`ADDR_PIN_MODE, `PIN_CYCLIC, "pin soft");
    check("pump_en soft", {7'h00, pump_output_enable}, 8'h01);
    wr(`ADDR_LOCK0_REG, 8'h00);
    wr(`ADDR_PIN_MODE, `PIN_WAKE);
    rdchk(`ADDR_PIN_MODE, `PIN_WAKE, "pin unlocked");
    wake_src_enable = 1'b1;
    wake_pulse(400, 8'h01);
    wake_pulse(100, 8'h00);
    wake_src_enable = 1'b0;
    fail_safe_mode = 1'b1;
    wake_pulse(400, 8'h01);
    fail_safe_mode = 1'b0;
    wake_pulse(400, 8'h00);
    // short frame must not commit
    host.frame(`ADDR_DUTY, 1'b1, 8'h55, 15, rd);
    rdchk(`ADDR_DUTY, 8'h00, "short frame");
    wr(`ADDR_PUMP_CTRL, 8'ha1);
    rdchk(`ADDR_PUMP_CTRL, 8'ha1, "lock1 frame");
    wr(`ADDR_PUMP_CTRL, 8'h40);
    rdchk(`ADDR_PUMP_CTRL, 8'ha1, "lock1 held");
    check("pump_cfg locked", {2'b00, pump_cfg}, 8'h28);
    do_soft();
    rdchk(`ADDR_PUMP_CTRL, 8'ha1, "lock1 soft");
    wr(`ADDR_PIN_MODE, `PIN_OFF);
    rdchk(`ADDR_PIN_MODE, `PIN_OFF, "pin outside lock1");
    // fastest rate, duty 1: only step 0 of the period drives
    wr(`ADDR_PERIOD_FREQ_SETTING, 8'h03);
    rdchk(`ADDR_PERIOD_FREQ_SETTING, 8'h03, "period_freq_setting");
    wr(`ADDR_DUTY, 8'h01);
    on_cyc = 0;
    wr(`ADDR_PIN_MODE, `PIN_PWM_LS);
    host.wait_cyc(400);
    check("ls on cycles", on_cyc[7:0], 8'(`PWM_STEP_CYC(`PWM_F3_HZ)));
    wr(`ADDR_PIN_MODE, `PIN_OFF);
    do_soft();
    rdchk(`ADDR_PERIOD_FREQ_SETTING, 8'h00, "period_freq_setting soft");
    // only power-on reset releases the level-1 lock
    rst_n = 1'b0;
    host.wait_cyc(2);
    rst_n = 1'b1;
    host.wait_cyc(2);
    rdchk(`ADDR_PUMP_CTRL, `PUMP_CTRL_POR, "pump after por");
    print_verdict();
  end
endmodule

// ==== tb/host_model.sv ====
// host side of the serial register port: frames 16-bit lsb-first transfers
// assumes the caller enters each task just after a rising clk edge
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk,
  // serial port
  output logic select_line_n,
  output logic spi_clk,
  output logic spi_di,
  input wire logic spi_do
);
  initial begin
    select_line_n = 1'b1;
    spi_clk = 1'b0;
    spi_di = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // nbits below 16 gives a frame the device must drop
  task automatic frame(input logic [6:0] addr, input logic wr, input logic [7:0] wdata, input int nbits,
                       output logic [7:0] rdata);
    logic [15:0] word;
    word = {wdata, wr, addr};
    rdata = 8'h00;
    select_line_n = 1'b0;
    wait_cyc(1);
    for (int i = 0; i < nbits; i++) begin
      spi_di = word[i];
      wait_cyc(2);
      if (i >= 8) begin
        rdata[i-8] = spi_do;
      end
      spi_clk = 1'b1;
      wait_cyc(3);
      spi_clk = 1'b0;
      wait_cyc(1);
    end
    // released data line must not keep its last level
    spi_di = ~spi_di;
    select_line_n = 1'b1;
    wait_cyc(4);
  endtask
endmodule
